// >>> design/servo_axis_command_sequencer.sv
// Status and command sequencing logic of one servo amplifier axis.
//
// Notes on behaviour
// - Encoder power-on completion echoes code 23 hex and sets command done.
// - Position-valid is 1 on successful acquisition, 0 when acquisition failed.
// - Incremental encoder axis reports position zero, acquires nothing.
// - Absolute axis coordinates equal detected position plus origin offset.
// - Origin offset accepted within plus/minus 1073741823, default 0, immediate.
// - Main-power-present is 1 when control and main circuit power present.
// - Motor-ready is 1 when main power present and position valid.
// - Motor-ready forced 0 by alarms, power off, no position, safety stop, init.
// - Host sends motor power-on only on ready; device then energizes motor.
// - Power-off while rotating stops non-spindle axes with the dynamic brake.
// - No electronic gear; references are taken in encoder pulse units.
// - Motor type digit 0..5, winding digit 0..1, defaults 0.
// - Encoder type digit 0..2, default 0.
// - Two selectable acceleration filters act on position references.
`timescale 1ns/1ps
`default_nettype none

module servo_axis_command_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic signed [31:0] targetPosition,
  input wire logic [1:0] filterSelect,
  input wire logic [3:0] filterShift,
  input wire logic originOffsetWrite,
  input wire logic signed [31:0] originOffsetValue,
  input wire logic [3:0] motorTypeValue,
  input wire logic [3:0] windingValue,
  input wire logic [3:0] encoderTypeValue,
  input wire logic typeWrite,
  input wire logic encDone,
  input wire logic encOk,
  input wire logic signed [31:0] encAbsPosition,
  input wire logic controlPowerIn,
  input wire logic mainPowerIn,
  input wire logic hardwireBaseblockInput,
  input wire logic motorRotatingIn,
  input wire logic [3:0] commAlarmCode,
  input wire logic deviceAlarmFlag,
  input wire logic paramsInitialized,
  output logic [7:0] responseCommandCode,
  output logic commandDoneFlag,
  output logic encoderPowerEnable,
  output servo_axis_pkg::axis_status_t axisStatus,
  output logic safetyStopFlag,
  output logic signed [31:0] commandPosition,
  output logic signed [31:0] feedbackPosition,
  output logic signed [31:0] filteredReference,
  output logic signed [31:0] originOffsetSetting,
  output logic [3:0] motorTypeSetting,
  output logic [3:0] windingSetting,
  output logic [3:0] encoderTypeSetting
);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ENC_WAIT = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;

  seq_state_t state_r;
  logic [1:0] pinSync1_r;
  logic [1:0] pinSync2_r;
  logic rotSync1_r;
  logic rotSync2_r;
  logic hwSync1_r;
  logic hwSync2_r;
  logic spindleAxis;
  logic incrementalAxis;
  logic readyCond;
  logic signed [31:0] filtAcc_r;
  logic signed [31:0] avgPrev_r;
  logic signed [31:0] expStep;
  logic posValid_r;
  logic powerFlag_r;
  logic ready_r;
  logic energized_r;
  logic brake_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Power, baseblock and rotation pins come from outside the clock domain.
  always_ff @(posedge clk) begin
    if (reset) begin
      pinSync1_r <= 2'b00;
      pinSync2_r <= 2'b00;
      rotSync1_r <= 1'b0;
      rotSync2_r <= 1'b0;
      hwSync1_r <= 1'b0;
      hwSync2_r <= 1'b0;
    end else begin
      pinSync1_r <= {controlPowerIn, mainPowerIn};
      pinSync2_r <= pinSync1_r;
      rotSync1_r <= motorRotatingIn;
      rotSync2_r <= rotSync1_r;
      hwSync1_r <= hardwireBaseblockInput;
      hwSync2_r <= hwSync1_r;
    end
  end

  // Spindle motor types mark a spindle axis; any encoder but the serial servo encoder marks an incremental axis.
  assign spindleAxis = (motorTypeSetting == servo_axis_pkg::MOTOR_SPM_SPINDLE)
    || (motorTypeSetting == servo_axis_pkg::MOTOR_SPINDLE)
    || (motorTypeSetting == servo_axis_pkg::MOTOR_IPM_SPINDLE);
  assign incrementalAxis = (encoderTypeSetting != servo_axis_pkg::ENC_SERIAL_SERVO);

  // Ready needs power and position, and no blocking condition at all.
  assign readyCond = axisStatus.mainPowerPresentFlag && axisStatus.positionValidFlag
    && (commAlarmCode < servo_axis_pkg::COMM_ALARM_LIMIT) && !deviceAlarmFlag
    && !safetyStopFlag && !paramsInitialized;

  // ----------------------------------------------------------------
  // Configuration settings
  // ----------------------------------------------------------------

  // Offset writes take effect at once; out-of-range values are ignored.
  always_ff @(posedge clk) begin
    if (reset) begin
      originOffsetSetting <= servo_axis_pkg::ORIGIN_OFFSET_RESET;
    end else if (originOffsetWrite && (originOffsetValue <= servo_axis_pkg::ORIGIN_OFFSET_MAX)
        && (originOffsetValue >= servo_axis_pkg::ORIGIN_OFFSET_MIN)) begin
      originOffsetSetting <= originOffsetValue;
    end
  end

  // Each digit keeps its old value when the written code is undefined.
  always_ff @(posedge clk) begin
    if (reset) begin
      motorTypeSetting <= servo_axis_pkg::MOTOR_TYPE_RESET;
      windingSetting <= servo_axis_pkg::WINDING_RESET;
      encoderTypeSetting <= servo_axis_pkg::ENCODER_TYPE_RESET;
    end else if (typeWrite) begin
      if (motorTypeValue <= servo_axis_pkg::MOTOR_TYPE_MAX) begin
        motorTypeSetting <= motorTypeValue;
      end
      if (windingValue <= servo_axis_pkg::WINDING_MAX) begin
        windingSetting <= windingValue;
      end
      if (encoderTypeValue <= servo_axis_pkg::ENCODER_TYPE_MAX) begin
        encoderTypeSetting <= encoderTypeValue;
      end
    end
  end

  // ----------------------------------------------------------------
  // Encoder power-on sequence
  // ----------------------------------------------------------------

  // The encoder interface reports completion on encDone; its timing is external.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= SEQ_IDLE;
      responseCommandCode <= servo_axis_pkg::CMD_NONE;
      commandDoneFlag <= 1'b0;
      encoderPowerEnable <= 1'b0;
      posValid_r <= 1'b0;
      commandPosition <= 32'sh00000000;
      feedbackPosition <= 32'sh00000000;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          if (cmdValid) begin
            responseCommandCode <= cmdCode;
            commandDoneFlag <= (cmdCode != servo_axis_pkg::CMD_ENCODER_POWER_ON);
            if (cmdCode == servo_axis_pkg::CMD_ENCODER_POWER_ON) begin
              encoderPowerEnable <= 1'b1;
              if (incrementalAxis) begin
                // Incremental axes skip acquisition and start from zero.
                commandPosition <= 32'sh00000000;
                feedbackPosition <= 32'sh00000000;
                posValid_r <= 1'b1;
                commandDoneFlag <= 1'b1;
                state_r <= SEQ_DONE;
              end else begin
                posValid_r <= 1'b0;
                state_r <= SEQ_ENC_WAIT;
              end
            end
          end
        end
        SEQ_ENC_WAIT: begin
          if (encDone) begin
            commandDoneFlag <= 1'b1;
            posValid_r <= encOk;
            if (encOk) begin
              commandPosition <= 32'(encAbsPosition + originOffsetSetting);
              feedbackPosition <= 32'(encAbsPosition + originOffsetSetting);
            end
            state_r <= SEQ_DONE;
          end
        end
        SEQ_DONE: begin
          // Later commands are answered but keep the acquired position.
          if (cmdValid) begin
            responseCommandCode <= cmdCode;
            commandDoneFlag <= 1'b1;
          end
          if (cmdValid && (cmdCode == servo_axis_pkg::CMD_ENCODER_POWER_ON)) begin
            responseCommandCode <= servo_axis_pkg::CMD_ENCODER_POWER_ON;
          end else if (!incrementalAxis && !pinSync2_r[1]) begin
            posValid_r <= 1'b0;
            encoderPowerEnable <= 1'b0;
            state_r <= SEQ_IDLE;
          end
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power status and motor energizing
  // ----------------------------------------------------------------

  // A power-off with the motor turning brakes feed axes but lets spindles coast.
  always_ff @(posedge clk) begin
    if (reset) begin
      powerFlag_r <= 1'b0;
      ready_r <= 1'b0;
      energized_r <= 1'b0;
      brake_r <= 1'b0;
      safetyStopFlag <= 1'b0;
    end else begin
      powerFlag_r <= pinSync2_r[1] && pinSync2_r[0];
      ready_r <= readyCond;
      safetyStopFlag <= !hwSync2_r;
      if (!readyCond) begin
        energized_r <= 1'b0;
      end else if (cmdValid && (cmdCode == servo_axis_pkg::CMD_MOTOR_POWER_ON)) begin
        energized_r <= 1'b1;
        brake_r <= 1'b0;
      end
      if (cmdValid && (cmdCode == servo_axis_pkg::CMD_MOTOR_POWER_OFF)) begin
        energized_r <= 1'b0;
        brake_r <= rotSync2_r && !spindleAxis;
      end else if (brake_r && !rotSync2_r) begin
        brake_r <= 1'b0;
      end
    end
  end

  // Each status bit is its own flop so that only one process writes it.
  assign axisStatus = {posValid_r, powerFlag_r, ready_r, energized_r, brake_r};

  // ----------------------------------------------------------------
  // Position reference filters
  // ----------------------------------------------------------------

  // The reference is already in encoder pulses, so no gear is applied.
  assign expStep = (targetPosition - filtAcc_r) >>> filterShift;

  // The moving average is a two-tap form, cheap but with a fixed short window.
  always_ff @(posedge clk) begin
    if (reset) begin
      filtAcc_r <= 32'sh00000000;
      avgPrev_r <= 32'sh00000000;
      filteredReference <= 32'sh00000000;
    end else begin
      avgPrev_r <= targetPosition;
      if (filterSelect == servo_axis_pkg::FILTER_EXPONENTIAL) begin
        filtAcc_r <= 32'(filtAcc_r + expStep);
        filteredReference <= 32'(filtAcc_r + expStep);
      end else begin
        filtAcc_r <= targetPosition;
        filteredReference <= 32'((64'(targetPosition) + 64'(avgPrev_r)) >>> 1);
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/servo_axis_pkg.sv
// Package of constants, encodings and carrier types for the servo axis command sequencer.
package servo_axis_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_ENCODER_POWER_ON = 8'h23;
  localparam logic [7:0] CMD_MOTOR_POWER_OFF = 8'h32;
  localparam logic [7:0] CMD_MOTOR_POWER_ON = 8'h31;

  // ----------------------------------------------------------------
  // Limits, thresholds and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] COMM_ALARM_LIMIT = 4'h8;
  localparam logic signed [31:0] ORIGIN_OFFSET_MAX = 32'sh3FFFFFFF;
  localparam logic signed [31:0] ORIGIN_OFFSET_MIN = -32'sh3FFFFFFF;
  localparam logic signed [31:0] ORIGIN_OFFSET_RESET = 32'sh00000000;
  localparam logic [3:0] MOTOR_TYPE_RESET = 4'h0;
  localparam logic [3:0] WINDING_RESET = 4'h0;
  localparam logic [3:0] ENCODER_TYPE_RESET = 4'h0;
  localparam logic [3:0] MOTOR_TYPE_MAX = 4'h5;
  localparam logic [3:0] WINDING_MAX = 4'h1;
  localparam logic [3:0] ENCODER_TYPE_MAX = 4'h2;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int ENC_WAIT_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ENC_WAIT_CYC = (ENC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_SHIFT_MAX = 15;

  // ----------------------------------------------------------------
  // Motor type, encoder type and filter select encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MOTOR_SERVO = 4'h0,
    MOTOR_SPM_SPINDLE = 4'h1,
    MOTOR_INDUCTION_SERVO = 4'h2,
    MOTOR_SPINDLE = 4'h3,
    MOTOR_IPM_SERVO = 4'h4,
    MOTOR_IPM_SPINDLE = 4'h5
  } motor_type_t;

  typedef enum logic [3:0] {
    ENC_SERIAL_SERVO = 4'h0,
    ENC_PULSE_SPINDLE = 4'h1,
    ENC_SERIAL_SPINDLE = 4'h2
  } encoder_type_t;

  typedef enum logic [1:0] {
    FILTER_EXPONENTIAL = 2'h0,
    FILTER_MOVING_AVG = 2'h1
  } filter_sel_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic positionValidFlag;
    logic mainPowerPresentFlag;
    logic motorReadyFlag;
    logic motorEnergized;
    logic dynamicBrake;
  } axis_status_t;

  typedef struct packed {
    logic [3:0] commAlarmCode;
    logic deviceAlarmFlag;
    logic safetyStopFlag;
    logic paramsInitialized;
  } alarm_in_t;

endpackage

// >>> test/encoder_model.sv
// Encoder acquisition responder standing at the far side of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic clk,
  input wire logic powerOn,
  input wire logic okIn,
  output logic encDone,
  output logic encOk
);
  logic [3:0] waitCnt_r;
  // Acquisition ends a fixed time after power rises; a power drop restarts it.
  always_ff @(posedge clk) begin
    if (!powerOn) waitCnt_r <= 4'h0;
    else if (waitCnt_r != 4'hF) waitCnt_r <= waitCnt_r + 4'h1;
  end
  // Outside the answer cycle the valid line shows the wrong level, so a stale read is caught.
  always_ff @(posedge clk) begin
    encDone <= powerOn && waitCnt_r == 4'h5;
    encOk <= (powerOn && waitCnt_r == 4'h5) ? okIn : !okIn;
  end
endmodule
`default_nettype wire

// >>> test/servo_axis_monitor.sv
// Concurrent checks on the ports of the axis command sequencer.
`timescale 1ns/1ps
`default_nettype none
module servo_axis_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic originOffsetWrite,
  input wire logic signed [31:0] originOffsetValue,
  input wire logic [3:0] motorTypeValue,
  input wire logic [3:0] windingValue,
  input wire logic [3:0] encoderTypeValue,
  input wire logic typeWrite,
  input wire logic encDone,
  input wire logic encOk,
  input wire logic signed [31:0] encAbsPosition,
  input wire logic controlPowerIn,
  input wire logic mainPowerIn,
  input wire logic motorRotatingIn,
  input wire logic [3:0] commAlarmCode,
  input wire logic deviceAlarmFlag,
  input wire logic paramsInitialized,
  input wire logic [7:0] responseCommandCode,
  input wire logic commandDoneFlag,
  input wire logic encoderPowerEnable,
  input wire servo_axis_pkg::axis_status_t axisStatus,
  input wire logic safetyStopFlag,
  input wire logic signed [31:0] feedbackPosition,
  input wire logic signed [31:0] originOffsetSetting,
  input wire logic [3:0] motorTypeSetting,
  input wire logic [3:0] windingSetting,
  input wire logic [3:0] encoderTypeSetting
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // An encoder answer that arrives while the power-on command is pending.
  sequence encWaiting;
    encDone && !commandDoneFlag && responseCommandCode == 8'h23;
  endsequence
  // Everything that motor-ready depends on is in its good state.
  logic readyOk;
  assign readyOk = axisStatus.mainPowerPresentFlag && axisStatus.positionValidFlag
    && commAlarmCode < 4'h8 && !deviceAlarmFlag && !paramsInitialized && !safetyStopFlag;
  sequence readyConds;
    readyOk;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  enc_echo_a: assert property (
    cmdValid && cmdCode == 8'h23 |=> responseCommandCode == 8'h23) else $error("no echo");
  enc_done_a: assert property (
    encWaiting |=> commandDoneFlag && responseCommandCode == 8'h23) else $error("no done");
  pos_valid_a: assert property (
    encWaiting |=> axisStatus.positionValidFlag == $past(encOk)) else $error("bad valid");
  incr_axis_a: assert property (
    cmdValid && cmdCode == 8'h23 && encoderTypeSetting != 4'h0 && !encoderPowerEnable
      |=> commandDoneFlag && axisStatus.positionValidFlag && feedbackPosition == 0)
    else $error("incremental acquired");
  abs_coord_a: assert property (
    encWaiting ##0 encOk
      |=> feedbackPosition == $past(encAbsPosition) + $past(originOffsetSetting))
    else $error("bad coordinate");
  offset_keep_a: assert property (
    originOffsetWrite && (originOffsetValue > 32'sh3FFFFFFF || originOffsetValue < -32'sh3FFFFFFF)
      |=> $stable(originOffsetSetting)) else $error("offset taken");
  power_flag_a: assert property (
    (controlPowerIn && mainPowerIn) [*4] |-> axisStatus.mainPowerPresentFlag)
    else $error("no power flag");
  ready_set_a: assert property (
    readyConds [*2] |-> axisStatus.motorReadyFlag) else $error("not ready");
  ready_hold_a: assert property (
    !readyOk |=> !axisStatus.motorReadyFlag) else $error("ready too early");
  motor_on_a: assert property (
    cmdValid && cmdCode == 8'h31 && axisStatus.motorReadyFlag && readyOk
      |=> ##[0:1] axisStatus.motorEnergized)
    else $error("not energized");
  brake_stop_a: assert property (
    motorRotatingIn [*3] ##0 (cmdValid && cmdCode == 8'h32 && !motorTypeSetting[0])
      |=> ##[0:3] axisStatus.dynamicBrake) else $error("no brake");
  type_write_a: assert property (
    typeWrite && motorTypeValue <= 4'h5 && windingValue <= 4'h1 && encoderTypeValue <= 4'h2
      |=> motorTypeSetting == $past(motorTypeValue) && windingSetting == $past(windingValue)
      && encoderTypeSetting == $past(encoderTypeValue)) else $error("type not taken");
endmodule
`default_nettype wire

// >>> test/tb_servo_axis_command_sequencer.sv
// Self-checking bench for the axis command sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_servo_axis_command_sequencer;
  logic clk, reset, cmdValid, originOffsetWrite, typeWrite, encDone, encOk, okIn;
  logic controlPowerIn, mainPowerIn, hardwireBaseblockInput, motorRotatingIn;
  logic deviceAlarmFlag, paramsInitialized, commandDoneFlag, encoderPowerEnable, safetyStopFlag;
  logic [7:0] cmdCode, responseCommandCode;
  logic [1:0] filterSelect;
  logic [3:0] filterShift, motorTypeValue, windingValue, encoderTypeValue, commAlarmCode;
  logic [3:0] motorTypeSetting, windingSetting, encoderTypeSetting;
  logic signed [31:0] targetPosition, originOffsetValue, encAbsPosition, commandPosition;
  logic signed [31:0] feedbackPosition, filteredReference, originOffsetSetting;
  servo_axis_pkg::axis_status_t axisStatus;
  int bad_count, comparisons, cycles;
  servo_axis_command_sequencer i_servo_axis_command_sequencer (.*);
  encoder_model i_encoder_model (.clk, .powerOn(encoderPowerEnable), .okIn, .encDone, .encOk);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // A command is a one-cycle strobe; the task leaves a cycle between two of them.
  task automatic send(input logic [7:0] code);
    cmdValid = 1'b1;
    cmdCode = code;
    tick(1);
    cmdValid = 1'b0;
    tick(1);
  endtask
  task automatic setOff(input logic signed [31:0] v);
    originOffsetWrite = 1'b1;
    originOffsetValue = v;
    tick(1);
    originOffsetWrite = 1'b0;
    tick(1);
  endtask
  task automatic setType(input logic [3:0] m, input logic [3:0] w, input logic [3:0] e);
    typeWrite = 1'b1;
    {motorTypeValue, windingValue, encoderTypeValue} = {m, w, e};
    tick(1);
    typeWrite = 1'b0;
    tick(1);
  endtask
  // The wait is bounded so a lost completion shows up as a mismatch.
  task automatic waitDone;
    for (int n = 0; n < 50 && commandDoneFlag !== 1'b1; n++) tick(1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {cmdValid, originOffsetWrite, typeWrite, okIn, motorRotatingIn, cmdCode} = '0;
    {deviceAlarmFlag, paramsInitialized, commAlarmCode, filterSelect, filterShift} = '0;
    {motorTypeValue, windingValue, encoderTypeValue, targetPosition, originOffsetValue} = '0;
    encAbsPosition = 32'sh00000064;
    {controlPowerIn, mainPowerIn, hardwireBaseblockInput, reset} = 4'hF;
    tick(8);
    reset = 1'b0;
    tick(1);
    chk("offset reset", 0, originOffsetSetting);
    setOff(32'sh3FFFFFFF);
    chk("offset max", 32'h3FFFFFFF, originOffsetSetting);
    setOff(32'sh40000000);
    chk("offset over", 32'h3FFFFFFF, originOffsetSetting);
    setOff(-32'sh00000005);
    chk("offset neg", 32'hFFFFFFFB, originOffsetSetting);
    okIn = 1'b1;
    send(8'h23);
    chk("response", 32'h23, responseCommandCode);
    waitDone();
    chk("done", 1, commandDoneFlag);
    chk("pos valid", 1, axisStatus.positionValidFlag);
    chk("feedback", 32'h5F, feedbackPosition);
    chk("command", 32'h5F, commandPosition);
    tick(2);
    chk("ready", 1, axisStatus.motorReadyFlag);
    send(8'h31);
    chk("energized", 1, axisStatus.motorEnergized);
    motorRotatingIn = 1'b1;
    tick(4);
    send(8'h32);
    tick(1);
    chk("brake on", 1, axisStatus.dynamicBrake);
    motorRotatingIn = 1'b0;
    tick(6);
    chk("brake off", 0, axisStatus.dynamicBrake);
    // A host that stops the motor first sees no braking on power-off.
    send(8'h31);
    send(8'h32);
    chk("stop no brake", 0, axisStatus.dynamicBrake);
    chk("power off", 0, axisStatus.motorEnergized);
    // Main power goes last; every pass restores the supply and clears the faults before the next.
    for (int i = 0; i < 6; i++) begin
      commAlarmCode = (i == 0) ? 4'h8 : (i == 4) ? 4'h7 : 4'h0;
      {deviceAlarmFlag, paramsInitialized} = {i == 1, i == 2};
      {hardwireBaseblockInput, mainPowerIn} = {i != 3, i != 5};
      tick(6);
      chk("ready held", i == 4, axisStatus.motorReadyFlag);
      chk("power flag", i != 5, axisStatus.mainPowerPresentFlag);
      chk("safety stop", i == 3, safetyStopFlag);
      {commAlarmCode, deviceAlarmFlag, paramsInitialized} = '0;
      {hardwireBaseblockInput, mainPowerIn} = 2'h3;
      tick(6);
    end
    for (int i = 0; i < 6; i++) begin
      setType(4'(i), 4'(i % 2), 4'(i % 3));
      chk("types", {4'(i), 4'(i % 2), 4'(i % 3)}, {motorTypeSetting, windingSetting, encoderTypeSetting});
    end
    setType(4'h6, 4'h2, 4'h3);
    chk("types kept", 32'h512, {motorTypeSetting, windingSetting, encoderTypeSetting});
    // The filter is switched from exponential to moving average in the middle of the move.
    filterShift = 4'h1;
    targetPosition = 32'sh00000040;
    tick(1);
    chk("exp filter 1", 32'h20, filteredReference);
    tick(1);
    chk("exp filter 2", 32'h30, filteredReference);
    filterSelect = 2'h1;
    tick(1);
    chk("avg filter 1", 32'h40, filteredReference);
    targetPosition = 32'sh00000080;
    tick(1);
    chk("avg filter 2", 32'h60, filteredReference);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    setType(4'h3, 4'h0, 4'h1);
    send(8'h23);
    chk("incr valid", 1, axisStatus.positionValidFlag);
    chk("incr position", 0, feedbackPosition);
    chk("incr enc power", 1, encoderPowerEnable);
    tick(10);
    chk("incr kept", 0, feedbackPosition);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    okIn = 1'b0;
    send(8'h23);
    waitDone();
    chk("fail valid", 0, axisStatus.positionValidFlag);
    chk("host alarm", 1, commandDoneFlag & ~axisStatus.positionValidFlag);
    tick(3);
    chk("fail ready", 0, axisStatus.motorReadyFlag);
    end_of_test();
  end
endmodule
bind servo_axis_command_sequencer servo_axis_monitor i_servo_axis_monitor (.*);
`default_nettype wire
